// >>> design/led_pwm_pkg.sv
// constants for the audio-synchronised three-output pwm light controller
// assumes a 250 MHz system clock and a two-wire write-only host link
package led_pwm_pkg;
  localparam int CLK_HZ = 250_000_000;
  // wishbone register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  // control register fields
  localparam int PAT_BIT = 0;
  localparam int SHUF_BIT = 1;
  localparam int DIR_LSB = 2;
  localparam int RATE_LSB = 5;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h20;
  // status register fields
  localparam int MAP_LSB = 0;
  localparam int LAST_BYTE_LSB = 8;
  // link address: upper six bits, then select pin, then write bit
  localparam logic [5:0] ADDR_HI = 6'h3D;
  // pwm rates in hertz and steps per pwm period
  localparam int PWM_HZ0 = 15000;
  localparam int PWM_HZ1 = 60;
  localparam int PWM_HZ2 = 7;
  localparam int PWM_HZ3 = 4;
  localparam int PWM_STEPS = 256;
  localparam int STEP_CYC0 = CLK_HZ / (PWM_HZ0 * PWM_STEPS);
  localparam int STEP_CYC1 = CLK_HZ / (PWM_HZ1 * PWM_STEPS);
  localparam int STEP_CYC2 = CLK_HZ / (PWM_HZ2 * PWM_STEPS);
  localparam int STEP_CYC3 = CLK_HZ / (PWM_HZ3 * PWM_STEPS);
  // band reassignment interval
  localparam int SHUFFLE_MS = 3200;
  localparam int SHUFFLE_CYC = (CLK_HZ / 1000) * SHUFFLE_MS;
  localparam logic [2:0] MAP_COUNT = 3'h6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_ADDR, S_DATA, S_ACK_DATA, S_IGNORE} link_state_t;
endpackage

// >>> design/audio_sync_led_pwm_control.sv
// three-output pwm light controller with audio and direct pattern modes
// assumes band levels come from logic on CLK_SYS; SCL, SDA_IN, ADR_SEL are async pins
// What this block does
// - eight address bits, msb first, sampled on rising clock edges.
// - respond only to address 111101X0, X taken from the select pin.
// - after a matching address, hold data low through the acknowledge pulse.
// - data bytes are eight bits, msb first, sampled on rising clock.
// - acknowledge every data byte by pulling data low for one pulse.
// - pattern select cleared gives audio-synchronised operation.
// - unshuffled: low band drives output 1, mid output 2, high output 3.
// - duty rises with the level of the assigned band.
// - shuffle enable bit turns band reassignment on and off.
// - shuffling acts only in audio mode, never in pattern mode.
// - while enabled, a new band mapping every 3.2 seconds.
// - pattern select set gives direct pattern mode.
// - in pattern mode each direct-on bit forces 100% or 0% duty.
// - two-bit rate field picks 15kHz, 60Hz, 7Hz or 4Hz for all outputs.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
module audio_sync_led_pwm_control #(
  parameter int STEP_CYC0 = led_pwm_pkg::STEP_CYC0,
  parameter int STEP_CYC1 = led_pwm_pkg::STEP_CYC1,
  parameter int STEP_CYC2 = led_pwm_pkg::STEP_CYC2,
  parameter int STEP_CYC3 = led_pwm_pkg::STEP_CYC3,
  parameter int SHUFFLE_CYC = led_pwm_pkg::SHUFFLE_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADR_SEL,
  input wire logic [7:0] BAND_LOW,
  input wire logic [7:0] BAND_MID,
  input wire logic [7:0] BAND_HIGH,
  output logic LIGHT_OUTPUT_1,
  output logic LIGHT_OUTPUT_2,
  output logic LIGHT_OUTPUT_3
);
  // wishbone slave
  logic next_ack;
  logic [31:0] next_rdata;
  logic wb_wr;
  // link receiver
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, adr_m, adr_s;
  led_pwm_pkg::link_state_t link_state, next_link_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift, last_byte, next_last_byte;
  logic next_sda_oe, byte_pulse, next_byte_pulse;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] own_addr;
  // control
  logic [6:0] ctrl, next_ctrl;
  logic pattern, shuffle_en;
  // band shuffle
  logic [31:0] shuf_timer, next_shuf_timer;
  logic [2:0] map_idx, next_map_idx;
  logic [3:0] map_sum;
  logic [7:0] lfsr, next_lfsr;
  logic shuf_tick;
  // pwm
  logic [31:0] presc, next_presc, step_lim;
  logic [7:0] step, next_step;
  logic [7:0] duty [3];
  logic [7:0] next_duty [3];
  logic [7:0] band [3];
  logic [2:0] light, next_light;
  logic load;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  assign wb_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  always_comb
  begin
    next_ack = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    case (WB_ADR_I)
      led_pwm_pkg::CTRL_OFS: next_rdata = {25'h0, ctrl};
      led_pwm_pkg::STATUS_OFS: next_rdata = {16'h0, last_byte, 5'h0, map_idx};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_rdata;
    end
  end

  // link receiver: pins pass two flops, edges come from the second and third
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign own_addr = {led_pwm_pkg::ADDR_HI, adr_s, 1'b0};

  always_comb
  begin
    next_link_state = link_state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_sda_oe = SDA_OE;
    next_byte_pulse = 1'b0;
    next_last_byte = last_byte;
    if (start_seen)
    begin
      next_link_state = led_pwm_pkg::S_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_seen)
    begin
      next_link_state = led_pwm_pkg::S_IDLE;
      next_sda_oe = 1'b0;
    end
    else
    begin
      case (link_state)
        led_pwm_pkg::S_ADDR, led_pwm_pkg::S_DATA:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == led_pwm_pkg::BITS_PER_BYTE)
          begin
            if (link_state == led_pwm_pkg::S_DATA)
            begin
              next_sda_oe = 1'b1;
              next_byte_pulse = 1'b1;
              next_last_byte = shift;
              next_link_state = led_pwm_pkg::S_ACK_DATA;
            end
            else if (shift == own_addr)
            begin
              next_sda_oe = 1'b1;
              next_link_state = led_pwm_pkg::S_ACK_ADDR;
            end
            else
            begin
              next_link_state = led_pwm_pkg::S_IGNORE;
            end
          end
        end
        led_pwm_pkg::S_ACK_ADDR, led_pwm_pkg::S_ACK_DATA:
        begin
          if (scl_fall)
          begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            next_link_state = led_pwm_pkg::S_DATA;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, adr_m, adr_s} <= 8'hFF;
      link_state <= led_pwm_pkg::S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      last_byte <= 8'h00;
      byte_pulse <= 1'b0;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end
    else
    begin
      scl_m <= SCL;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
      adr_m <= ADR_SEL;
      adr_s <= adr_m;
      link_state <= next_link_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      last_byte <= next_last_byte;
      byte_pulse <= next_byte_pulse;
      SDA_OE <= next_sda_oe;
      SDA_OUT <= 1'b0;
    end
  end

  // control register: written by link bytes and by wishbone, wishbone wins
  assign pattern = ctrl[led_pwm_pkg::PAT_BIT];
  assign shuffle_en = ctrl[led_pwm_pkg::SHUF_BIT] & ~pattern;

  always_comb
  begin
    next_ctrl = ctrl;
    if (byte_pulse)
      next_ctrl = last_byte[led_pwm_pkg::CTRL_W-1:0];
    if (wb_wr && WB_ADR_I == led_pwm_pkg::CTRL_OFS && WB_SEL_I[0])
      next_ctrl = WB_DAT_I[led_pwm_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      ctrl <= led_pwm_pkg::CTRL_RST;
    else
      ctrl <= next_ctrl;
  end

  // band shuffle: step the mapping by one or two places every interval
  assign shuf_tick = shuffle_en && shuf_timer == 32'(SHUFFLE_CYC - 1);
  assign map_sum = {1'b0, map_idx} + 4'h1 + {3'h0, lfsr[0]};

  always_comb
  begin
    next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    next_shuf_timer = shuf_timer + 32'h1;
    next_map_idx = map_idx;
    if (!shuffle_en)
    begin
      next_shuf_timer = 32'h0;
      next_map_idx = 3'h0;
    end
    else if (shuf_tick)
    begin
      next_shuf_timer = 32'h0;
      if (map_sum >= {1'b0, led_pwm_pkg::MAP_COUNT})
        next_map_idx = 3'(map_sum - {1'b0, led_pwm_pkg::MAP_COUNT});
      else
        next_map_idx = map_sum[2:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lfsr <= 8'h01;
      shuf_timer <= 32'h0;
      map_idx <= 3'h0;
    end
    else
    begin
      lfsr <= next_lfsr;
      shuf_timer <= next_shuf_timer;
      map_idx <= next_map_idx;
    end
  end

  // pwm: 256 steps a period, duties reloaded at each period start
  assign load = (presc == step_lim - 32'h1) && step == 8'hFF;

  always_comb
  begin
    case (ctrl[led_pwm_pkg::RATE_LSB +: 2])
      2'h0: step_lim = 32'(STEP_CYC0);
      2'h1: step_lim = 32'(STEP_CYC1);
      2'h2: step_lim = 32'(STEP_CYC2);
      default: step_lim = 32'(STEP_CYC3);
    endcase
    case (map_idx)
      3'h0: band = '{BAND_LOW, BAND_MID, BAND_HIGH};
      3'h1: band = '{BAND_MID, BAND_HIGH, BAND_LOW};
      3'h2: band = '{BAND_HIGH, BAND_LOW, BAND_MID};
      3'h3: band = '{BAND_LOW, BAND_HIGH, BAND_MID};
      3'h4: band = '{BAND_HIGH, BAND_MID, BAND_LOW};
      default: band = '{BAND_MID, BAND_LOW, BAND_HIGH};
    endcase
    next_presc = presc + 32'h1;
    next_step = step;
    if (presc >= step_lim - 32'h1)
    begin
      next_presc = 32'h0;
      next_step = step + 8'h1;
    end
    for (int i = 0; i < 3; i++)
    begin
      next_duty[i] = duty[i];
      if (load && pattern)
        next_duty[i] = {8{ctrl[led_pwm_pkg::DIR_LSB + i]}};
      else if (load)
        next_duty[i] = band[i];
      next_light[i] = (duty[i] == 8'hFF) | (step < duty[i]);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      presc <= 32'h0;
      step <= 8'h00;
      duty <= '{8'h00, 8'h00, 8'h00};
      light <= 3'h0;
      LIGHT_OUTPUT_1 <= 1'b0;
      LIGHT_OUTPUT_2 <= 1'b0;
      LIGHT_OUTPUT_3 <= 1'b0;
    end
    else
    begin
      presc <= next_presc;
      step <= next_step;
      duty <= next_duty;
      light <= next_light;
      LIGHT_OUTPUT_1 <= next_light[0];
      LIGHT_OUTPUT_2 <= next_light[1];
      LIGHT_OUTPUT_3 <= next_light[2];
    end
  end

  a_addr_match: assert property (($rose(SDA_OE) && link_state == led_pwm_pkg::S_ACK_ADDR)
    |-> $past(shift) == own_addr) else $error("address acknowledged without match");
  a_foreign_silent: assert property (link_state == led_pwm_pkg::S_IGNORE |-> !SDA_OE)
    else $error("foreign transfer acknowledged");
  a_ack_held: assert property ((SDA_OE && !scl_fall && !start_seen && !stop_seen) |=> SDA_OE)
    else $error("acknowledge released early");
  a_byte_ctrl: assert property ((byte_pulse && !wb_wr) |=> ctrl == $past(last_byte[6:0]))
    else $error("link byte not stored");
  a_pattern_duty: assert property ((load && pattern) |=> duty[0] == {8{$past(ctrl[2])}})
    else $error("pattern duty wrong");
  a_audio_map: assert property ((load && !pattern && map_idx == 3'h0) |=> duty[0] == $past(BAND_LOW))
    else $error("low band not on output one");
  a_full_dark: assert property (duty[0] == 8'h00 |=> !LIGHT_OUTPUT_1)
    else $error("zero duty lit the output");
  a_full_on: assert property (duty[2] == 8'hFF |=> LIGHT_OUTPUT_3)
    else $error("full duty left the output dark");
  a_shuffle_off: assert property ((pattern || !ctrl[1]) |=> map_idx == 3'h0)
    else $error("mapping moved while shuffle inactive");
  a_shuffle_step: assert property (shuf_tick |=> map_idx != $past(map_idx) && map_idx < 3'h6)
    else $error("shuffle did not change mapping");
endmodule

// >>> testbench/link_host_model.sv
// two-wire host model: start, bytes with acknowledge check, stop
// assumes the bench resolves the wired-and data line and feeds it back on sda
module link_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #8 sda_drv = v[i];
      #8 scl = 1'b1;
      #16 scl = 1'b0;
    end
    #8 sda_drv = 1'b1;
    #8 scl = 1'b1;
    #8 ack = (sda === 1'b0);
    #8 scl = 1'b0;
  endtask
  task automatic transfer(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
    output logic [2:0] acks);
    acks = 3'h0;
    #16 sda_drv = 1'b0;
    #16 scl = 1'b0;
    put_byte(a, acks[0]);
    if (acks[0])
    begin
      put_byte(d0, acks[1]);
      put_byte(d1, acks[2]);
    end
    #8 sda_drv = 1'b0;
    #8 scl = 1'b1;
    #16 sda_drv = 1'b1;
    #16;
  endtask
endmodule

// >>> testbench/audio_sync_led_pwm_control_tb.sv
// self-checking bench for the pwm light controller
// assumes the host model is compiled first; small step and shuffle counts
`define CHK(a, b) \
  begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module audio_sync_led_pwm_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] val; logic [31:0] mask;} exp_t;
  localparam int STEP[4] = '{2, 3, 4, 5};
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, adr_sel;
  logic scl, host_sda, sda, sda_out, sda_oe, l1, l2, l3;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, d0;
  logic [7:0] band[3] = '{8'h00, 8'h00, 8'h00};
  logic [31:0] dat = 32'h0, rdat, last;
  logic [2:0] acks;
  int errors = 0, check_count = 0, cyc_n = 0, c[3];
  exp_t exp_q[$];
  assign sda = host_sda & ~(sda_oe & ~sda_out);
  audio_sync_led_pwm_control #(.STEP_CYC0(2), .STEP_CYC1(3), .STEP_CYC2(4), .STEP_CYC3(5),
    .SHUFFLE_CYC(50)) audio_sync_led_pwm_control_i (
    .CLK_SYS(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADR_SEL(adr_sel),
    .BAND_LOW(band[0]), .BAND_MID(band[1]), .BAND_HIGH(band[2]),
    .LIGHT_OUTPUT_1(l1), .LIGHT_OUTPUT_2(l2), .LIGHT_OUTPUT_3(l3));
  link_host_model link_host_model_i (.scl(scl), .sda_drv(host_sda), .sda(sda));
  always #2 clk = ~clk;
  task automatic test_done();
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 80000)
    begin
      errors++;
      test_done();
    end
  end
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0)
    begin
      `CHK(rdat & exp_q[0].mask, exp_q[0].val)
      exp_q.delete(0);
    end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
      errors++;
    last = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wbr(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v & m, m});
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic meas(input int win);
    c = '{0, 0, 0};
    repeat (win)
    begin
      @(posedge clk);
      c[0] += (l1 === 1'b1);
      c[1] += (l2 === 1'b1);
      c[2] += (l3 === 1'b1);
    end
  endtask
  initial
  begin
    void'($urandom(32'h05B6));
    adr_sel = 1'($urandom);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wbr(8'h00, 32'h20, '1);
    wbr(8'h08, 32'h0, '1);
    wb(1'b1, 8'h04, 32'hFFFF, 4'hF);
    wbr(8'h04, 32'h0, '1);
    wb(1'b1, 8'h00, 32'h7F, 4'hE);
    wbr(8'h00, 32'h20, '1);
    d0 = 8'($urandom);
    link_host_model_i.transfer({6'h3D, adr_sel, 1'b0}, d0, 8'hC5, acks);
    `CHK(acks, 3'h7)
    wbr(8'h04, 32'hC500, 32'hFF00);
    wbr(8'h00, 32'h45, '1);
    link_host_model_i.transfer({6'h3D, ~adr_sel, 1'b0}, 8'h00, 8'h00, acks);
    `CHK(acks, 3'h0)
    link_host_model_i.transfer({6'h3D, adr_sel, 1'b1}, 8'h00, 8'h00, acks);
    `CHK(acks, 3'h0)
    wbr(8'h00, 32'h45, '1);
    @(posedge clk);
    adr_sel <= ~adr_sel;
    repeat (6) @(posedge clk);
    link_host_model_i.transfer({6'h3D, adr_sel, 1'b0}, 8'h11, 8'h45, acks);
    `CHK(acks, 3'h7)
    wbr(8'h04, 32'h4500, 32'hFF00);
    wbr(8'h00, 32'h45, '1);
    for (int d = 0; d < 8; d++)
    begin
      foreach (band[k]) band[k] <= 8'($urandom);
      wb(1'b1, 8'h00, 32'(d << 2 | 3), 4'h1);
      repeat (1100) @(posedge clk);
      meas(256 * STEP[0]);
      for (int k = 0; k < 3; k++)
        `CHK(c[k], d[k] ? 256 * STEP[0] : 0)
    end
    wbr(8'h04, 32'h0, 32'h7);
    for (int r = 0; r < 4; r++)
    begin
      foreach (band[k]) band[k] <= 8'($urandom);
      wb(1'b1, 8'h00, 32'(r << 5), 4'h1);
      repeat (2600) @(posedge clk);
      meas(256 * STEP[r]);
      for (int k = 0; k < 3; k++)
        `CHK(c[k], band[k] == 8'hFF ? 256 * STEP[r] : band[k] * STEP[r])
    end
    wb(1'b1, 8'h00, 32'h22, 4'h1);
    repeat (25) @(posedge clk);
    wbr(8'h04, 32'h0, 32'h7);
    repeat (30) @(posedge clk);
    wbr(8'h04, 32'h0, 32'h0);
    `CHK(last[2:0] inside {3'h1, 3'h2}, 1'b1)
    repeat (50) @(posedge clk);
    wbr(8'h04, 32'h0, 32'h0);
    `CHK(last[2:0] inside {3'h2, 3'h3, 3'h4}, 1'b1)
    wb(1'b1, 8'h00, 32'h20, 4'h1);
    wbr(8'h04, 32'h0, 32'h7);
    test_done();
  end
endmodule
